// ===== core/apfg_pkg.sv
// Constants and carrier types of the antenna pointing function generator
package apfg_pkg;
    // =====
    // Data widths
    localparam int ANG_W = 14;
    localparam int INC_W = 6;
    localparam int LOAD_W = 20;
    localparam int MT_W = 26;
    localparam int TAG_W = 14;
    localparam int MT_HI_LSB = MT_W - TAG_W;
    localparam int SEG_MAX = 9;
    localparam int SEG_IDX_W = 4;
    localparam int CNT_W = 5;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    // =====
    // Phase sequencer
    localparam int PHASE_CNT_W = 2;
    localparam logic [PHASE_CNT_W-1:0] PHASE_ONE_SLOT = 2'h0;
    localparam logic [PHASE_CNT_W-1:0] PHASE_TWO_SLOT = 2'h2;
    // =====
    // Register map (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_TAG0 = 8'h20;
    localparam logic [ADDR_W-1:0] TAG_SPAN = 8'h24;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // =====
    // Control register, low bits of the word
    typedef struct packed {
        logic inhibit;
        logic [SEG_IDX_W-1:0] segCount;
        logic [SEG_IDX_W-1:0] stepSel;
        logic run;
    } apfg_ctrl_t;
    localparam int CTRL_W = $bits(apfg_ctrl_t);
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    // Status register, low bits of the word
    typedef struct packed {
        logic loading;
        logic busy;
        logic [SEG_IDX_W-1:0] segIdx;
        logic [INC_W-1:0] incr;
        logic [ANG_W-1:0] angle;
    } apfg_stat_t;
    localparam int STAT_W = $bits(apfg_stat_t);
    // Serial start-data source: new-data level, data bit, transfer clock
    typedef struct packed {
        logic newData;
        logic data;
        logic xclk;
    } apfg_stream_t;
    localparam int STREAM_W = $bits(apfg_stream_t);
endpackage

// ===== core/apfg_phase_clock.sv
// Two-phase non-overlapping sequencing pulses derived from the system clock
`timescale 1ns/1ns
module apfg_phase_clock
    import apfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    output logic clockPhaseOne,
    output logic clockPhaseTwo
);
    // =====
    // Free-running slot counter
    logic [PHASE_CNT_W-1:0] phaseCnt; // Current slot

    // Each phase owns one slot; idle slots between keep them apart
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phaseCnt <= '0;
            clockPhaseOne <= 1'b0;
            clockPhaseTwo <= 1'b0;
        end else begin
            phaseCnt <= phaseCnt + 2'h1;
            clockPhaseOne <= (phaseCnt == PHASE_ONE_SLOT);
            clockPhaseTwo <= (phaseCnt == PHASE_TWO_SLOT);
        end
    end
endmodule

// ===== core/apfg_serial_adder.sv
// Bit-serial full adder with carry and carry-delay flip-flops
`timescale 1ns/1ns
module apfg_serial_adder (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear,
    input wire logic stepOne,
    input wire logic stepTwo,
    input wire logic addendA,
    input wire logic addendB,
    output logic sum
);
    // =====
    // Carry path
    logic carry; // Carry caught on phase one
    logic carryDly; // Carry offered to the next bit
    wire carryOut = (addendA & addendB) | (addendA & carryDly) | (addendB & carryDly);

    assign sum = addendA ^ addendB ^ carryDly;

    // Two flops so the sum bit never races its own carry
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            carry <= 1'b0;
            carryDly <= 1'b0;
        end else if (clear) begin
            carry <= 1'b0;
            carryDly <= 1'b0;
        end else begin
            if (stepOne) begin
                carry <= carryOut;
            end
            if (stepTwo) begin
                carryDly <= carry;
            end
        end
    end
endmodule

// ===== core/apfg_function_generator.sv
// Antenna pointing function generator: segment loader, stepper, gimbal output
// Operation
// - Start data from memory or ground stream
// - Up to nine segments, own start/increment
// - 14-bit tag matched to mission clock top
// - Step timing from selected mission clock bit
// - Angle register 14 bits, increment 6 bits
// - Segment load presents start angle immediately
// - Serial full adder adds increment each step
// - Control signal plus 14-bit serial angle stream
// - Steps repeat until new start data arrives
// - New-data signal, then 20-bit serial load
// - Transfer clears carry and carry-delay flops
// - Two-phase non-overlapping pulses sequence all work
// - Maneuver inhibit suppresses all antenna output
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module apfg_function_generator
    import apfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [MT_W-1:0] missionTime,
    input wire apfg_stream_t memStream,
    input wire apfg_stream_t gndStream,
    output logic segRequest,
    output logic gimbalCtl,
    output logic gimbalData,
    output logic gimbalClk
);
    // =====
    // Helpers
    // Byte-lane merge of a write into an old word
    function automatic logic [DATA_W-1:0] mergeStrb(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] data,
        input logic [3:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction
    // True for an aligned address inside the time tag table
    function automatic logic isTag(input logic [ADDR_W-1:0] addr);
        return (addr >= OFF_TAG0) && (addr < OFF_TAG0 + TAG_SPAN) && (addr[1:0] == 2'h0);
    endfunction
    // Table index of a tag address
    function automatic logic [SEG_IDX_W-1:0] tagIdx(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] d;
        d = addr - OFF_TAG0;
        return d[SEG_IDX_W+1:2];
    endfunction
    // =====
    // State
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_ADD, ST_SEND} apfg_state_t;
    apfg_state_t state; // Sequencer state
    apfg_ctrl_t ctrl; // Software control
    logic [TAG_W-1:0] tagMem [SEG_MAX]; // Segment start time tags
    logic [SEG_IDX_W-1:0] segIdx; // Next segment to start
    logic [ANG_W-1:0] angle; // Present pointing angle
    logic [INC_W-1:0] incr; // Present increment, two's complement
    logic [LOAD_W-1:0] ldShift; // Incoming start data
    logic [ANG_W-1:0] sendShift; // Outgoing angle bits
    logic [CNT_W-1:0] bitCnt; // Bits loaded, added or sent
    logic haveData; // Angle and increment are valid
    logic stepPend; // Computation time seen, not yet served
    logic stepDly; // Last sample of step bit
    logic srcGnd; // Load comes from ground
    logic bitRdy; // Transfer bit waits for phase one
    logic bitVal; // That bit
    logic [1:0] xclkDly; // Last transfer clocks, memory and ground
    logic phaseOne; // Sequencing pulse one
    logic phaseTwo; // Sequencing pulse two
    logic addSum; // Serial adder output
    logic wrCtrl; // Control write commits this cycle
    // =====
    // Pin synchronisers
    logic [2*STREAM_W-1:0] pinMeta; // First stage, read only by second
    logic [2*STREAM_W-1:0] pinSync; // Second stage
    // Both stream pins arrive from outside the clock domain
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= {memStream, gndStream};
            pinSync <= pinMeta;
        end
    end
    wire apfg_stream_t memSync = apfg_stream_t'(pinSync[2*STREAM_W-1:STREAM_W]);
    wire apfg_stream_t gndSync = apfg_stream_t'(pinSync[STREAM_W-1:0]);
    wire apfg_stream_t selSync = srcGnd ? gndSync : memSync;
    wire selXclkDly = srcGnd ? xclkDly[0] : xclkDly[1];
    wire xferEdge = selSync.xclk & ~selXclkDly;
    wire anyNew = memSync.newData | gndSync.newData;
    // Sequencing pulses and the serial adder
    apfg_phase_clock apfg_phase_clock_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .clockPhaseOne(phaseOne),
        .clockPhaseTwo(phaseTwo)
    );
    wire incrBit = (bitCnt < CNT_W'(INC_W)) ? incr[bitCnt[2:0]] : incr[INC_W-1];
    wire addClear = (state != ST_ADD);
    apfg_serial_adder apfg_serial_adder_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(addClear),
        .stepOne(phaseOne),
        .stepTwo(phaseTwo),
        .addendA(angle[0]),
        .addendB(incrBit),
        .sum(addSum)
    );
    // =====
    // Timing decode
    wire [TAG_W-1:0] missionHi = missionTime[MT_W-1:MT_HI_LSB];
    wire [SEG_IDX_W-1:0] stepSelSafe = (ctrl.stepSel < SEG_IDX_W'(TAG_W)) ? ctrl.stepSel : '0;
    wire stepBit = missionTime[MT_HI_LSB + int'(stepSelSafe)];
    wire segLimitOk = (segIdx < ctrl.segCount) && (segIdx < SEG_IDX_W'(SEG_MAX));
    wire tagHit = ctrl.run && segLimitOk && (missionHi == tagMem[segIdx]);
    wire loadDone = (state == ST_LOAD) && phaseOne && bitRdy
        && (bitCnt == CNT_W'(LOAD_W - 1));
    wire addDone = (state == ST_ADD) && phaseOne && (bitCnt == CNT_W'(ANG_W - 1));
    wire sendDone = (state == ST_SEND) && phaseTwo && (bitCnt == CNT_W'(ANG_W));
    wire sendActive = (state == ST_SEND) && !ctrl.inhibit;
    wire [LOAD_W-1:0] ldNext = {bitVal, ldShift[LOAD_W-1:1]};
    wire [ANG_W-1:0] addNext = {addSum, angle[ANG_W-1:1]};
    // Step capture, a new edge wins over the clear; one request per matched tag
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stepDly <= 1'b0;
            stepPend <= 1'b0;
            segIdx <= '0;
            segRequest <= 1'b0;
        end else begin
            stepDly <= stepBit;
            if (stepBit && !stepDly) begin
                stepPend <= 1'b1;
            end else if (state == ST_IDLE && !anyNew && haveData && ctrl.run) begin
                stepPend <= 1'b0;
            end
            segRequest <= tagHit;
            if (wrCtrl) begin
                segIdx <= '0;
            end else if (tagHit) begin
                segIdx <= segIdx + 4'h1;
            end
        end
    end
    // =====
    // Sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            bitCnt <= '0;
            srcGnd <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    bitCnt <= '0;
                    if (anyNew) begin
                        srcGnd <= !memSync.newData;
                        state <= ST_LOAD;
                    end else if (stepPend && haveData && ctrl.run) begin
                        state <= ST_ADD;
                    end
                end
                ST_LOAD: begin
                    if (!selSync.newData) begin
                        state <= ST_IDLE; // Stream dropped: keep old values
                    end else if (loadDone) begin
                        bitCnt <= '0;
                        state <= ST_SEND;
                    end else if (phaseOne && bitRdy) begin
                        bitCnt <= bitCnt + 5'h01;
                    end
                end
                ST_ADD: begin
                    if (addDone) begin
                        bitCnt <= '0;
                        state <= ST_SEND;
                    end else if (phaseOne) begin
                        bitCnt <= bitCnt + 5'h01;
                    end
                end
                ST_SEND: begin
                    if (ctrl.inhibit || sendDone) begin
                        state <= ST_IDLE;
                    end else if (phaseOne) begin
                        bitCnt <= bitCnt + 5'h01;
                    end
                end
            endcase
        end
    end
    // Transfer bits are caught on their clock, shifted on phase one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            xclkDly <= 2'h0;
            bitRdy <= 1'b0;
            bitVal <= 1'b0;
            ldShift <= '0;
        end else begin
            xclkDly <= {memSync.xclk, gndSync.xclk};
            if (state == ST_LOAD && xferEdge) begin
                bitRdy <= 1'b1;
                bitVal <= selSync.data;
            end else if (state != ST_LOAD || phaseOne) begin
                bitRdy <= 1'b0;
            end
            if (state == ST_LOAD && phaseOne && bitRdy) begin
                ldShift <= ldNext;
            end
        end
    end
    // Angle and increment registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            angle <= '0;
            incr <= '0;
            haveData <= 1'b0;
        end else if (loadDone) begin
            angle <= ldNext[ANG_W-1:0];
            incr <= ldNext[LOAD_W-1:ANG_W];
            haveData <= 1'b1;
        end else if (state == ST_ADD && phaseOne) begin
            angle <= addNext;
        end
    end
    // =====
    // Gimbal output: frame level, data on phase one, clock on phase two
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sendShift <= '0;
            gimbalCtl <= 1'b0;
            gimbalData <= 1'b0;
            gimbalClk <= 1'b0;
        end else begin
            if (loadDone) begin
                sendShift <= ldNext[ANG_W-1:0];
            end else if (addDone) begin
                sendShift <= addNext;
            end else if (state == ST_SEND && phaseOne) begin
                sendShift <= sendShift >> 1;
            end
            gimbalCtl <= sendActive && !sendDone;
            if (sendActive && phaseOne && bitCnt < CNT_W'(ANG_W)) begin
                gimbalData <= sendShift[0];
            end else if (!sendActive) begin
                gimbalData <= 1'b0;
            end
            gimbalClk <= sendActive && phaseTwo && (bitCnt != '0);
        end
    end
    // =====
    // AXI4-Lite write channel
    logic awHeld; // Address taken, write pending
    logic wHeld; // Data taken, write pending
    logic [ADDR_W-1:0] awAddrQ; // Held address
    logic [DATA_W-1:0] wDataQ; // Held data
    logic [3:0] wStrbQ; // Held strobes
    wire awTake = s_axi_awvalid & s_axi_awready;
    wire wTake = s_axi_wvalid & s_axi_wready;
    wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
    assign wrCtrl = doWrite && (awAddrQ == OFF_CTRL);
    wire wrTag = doWrite && isTag(awAddrQ);
    wire wrOk = (awAddrQ == OFF_CTRL) || (awAddrQ == OFF_STAT) || isTag(awAddrQ);
    wire nextAwHeld = awTake | (awHeld & ~doWrite);
    wire nextWHeld = wTake | (wHeld & ~doWrite);
    // Address and data may come in either order; held until both are here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            awHeld <= nextAwHeld;
            wHeld <= nextWHeld;
            s_axi_awready <= !nextAwHeld;
            s_axi_wready <= !nextWHeld;
            if (awTake) begin
                awAddrQ <= s_axi_awaddr;
            end
            if (wTake) begin
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Control and tag table stores; status is read-only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= apfg_ctrl_t'(CTRL_RST);
            for (int i = 0; i < SEG_MAX; i++) begin
                tagMem[i] <= '0;
            end
        end else if (wrCtrl) begin
            ctrl <= apfg_ctrl_t'(mergeStrb(DATA_W'(ctrl), wDataQ, wStrbQ));
        end else if (wrTag) begin
            tagMem[tagIdx(awAddrQ)] <=
                TAG_W'(mergeStrb(DATA_W'(tagMem[tagIdx(awAddrQ)]), wDataQ, wStrbQ));
        end
    end
    // =====
    // AXI4-Lite read channel
    apfg_stat_t stat;
    assign stat = '{loading: (state == ST_LOAD), busy: (state != ST_IDLE),
        segIdx: segIdx, incr: incr, angle: angle};
    wire rdTag = isTag(s_axi_araddr);
    wire rdOk = (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_STAT) || rdTag;
    wire [DATA_W-1:0] rdMux =
        (s_axi_araddr == OFF_CTRL) ? DATA_W'(ctrl) :
        (s_axi_araddr == OFF_STAT) ? DATA_W'(stat) :
        rdTag ? DATA_W'(tagMem[tagIdx(s_axi_araddr)]) : '0;
    wire arTake = s_axi_arvalid & s_axi_arready;
    // One read at a time; address ready drops while data waits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (arTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ===== tb/apfg_monitor.sv
// Checker of gimbal frames and bus answers of the pointing generator
`timescale 1ns/1ns
module apfg_monitor
    import apfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic gimbalCtl,
    input wire logic gimbalData,
    input wire logic gimbalClk
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // =====
    // Bit pulses counted per frame
    logic [4:0] bitCnt;
    logic ctlQ;
    // Restart at each frame start, so a stray pulse shows as a long frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bitCnt <= 5'h00;
            ctlQ <= 1'b0;
        end else begin
            ctlQ <= gimbalCtl;
            if (gimbalCtl && !ctlQ) bitCnt <= {4'h0, gimbalClk};
            else if (gimbalClk) bitCnt <= bitCnt + 5'h01;
        end
    end
    // =====
    // Properties
    sequence s_bitSlot;
        gimbalClk ##1 !gimbalClk [*3];
    endsequence
    sequence s_readTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_bitSpacing;
        gimbalClk |-> s_bitSlot;
    endproperty
    property p_clkInFrame;
        gimbalClk |-> gimbalCtl || $past(gimbalCtl);
    endproperty
    property p_dataStable;
        gimbalClk |-> $stable(gimbalData);
    endproperty
    property p_frameLen;
        $fell(gimbalCtl) |-> ##[0:4] (bitCnt == 5'h0E);
    endproperty
    property p_maxBits;
        gimbalClk && ctlQ |-> bitCnt < 5'h0E;
    endproperty
    property p_rAnswer;
        s_readTake |=> s_axi_rvalid;
    endproperty
    property p_rHold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_bHold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_arBusy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_bitSpacing: assert property (p_bitSpacing)
        else $error("gimbal bit pulses too close");
    a_clkInFrame: assert property (p_clkInFrame)
        else $error("gimbal pulse outside a frame");
    a_dataStable: assert property (p_dataStable)
        else $error("gimbal data moved at its pulse");
    a_frameLen: assert property (p_frameLen)
        else $error("frame without fourteen bits");
    a_maxBits: assert property (p_maxBits)
        else $error("frame longer than fourteen bits");
    a_rAnswer: assert property (p_rAnswer)
        else $error("read answer late");
    a_rHold: assert property (p_rHold)
        else $error("read answer dropped");
    a_bHold: assert property (p_bHold)
        else $error("write answer dropped");
    a_arBusy: assert property (p_arBusy)
        else $error("read taken while answering");
endmodule

// ===== tb/apfg_stream_source.sv
// Serial start-data source standing for memory or ground command
`timescale 1ns/1ns
module apfg_stream_source
    import apfg_pkg::*;
(
    input wire logic clk_sys,
    output apfg_stream_t stream
);
    // Transfer clock rests low between loads
    initial stream = '0;
    // Angle then increment, LSB first, eight cycles per level
    task automatic send(input logic [LOAD_W-1:0] word);
        @(posedge clk_sys);
        stream.newData <= 1'b1;
        for (int k = 0; k < LOAD_W; k++) begin
            stream.data <= word[k];
            repeat (8) @(posedge clk_sys);
            stream.xclk <= 1'b1;
            repeat (8) @(posedge clk_sys);
            stream.xclk <= 1'b0;
        end
        stream.newData <= 1'b0;
        // Released line shows the inverse, never a stale level
        stream.data <= ~word[LOAD_W-1];
    endtask
endmodule

// ===== tb/apfg_function_generator_tb_top.sv
// Self-checking bench of the antenna pointing function generator
`timescale 1ns/1ns
module apfg_function_generator_tb_top
    import apfg_pkg::*;
;
    logic clk_sys, rst, awValid, wValid, bReady, arValid, rReady;
    logic [ADDR_W-1:0] awAddr, arAddr;
    logic [DATA_W-1:0] wData;
    logic [MT_W-1:0] missionTime;
    wire logic awReady, wReady, bValid, arReady, rValid, segRequest;
    wire logic gimbalCtl, gimbalData, gimbalClk;
    wire logic [1:0] bResp, rResp;
    wire logic [DATA_W-1:0] rData;
    apfg_stream_t memStream, gndStream;
    int bad_count = 0;
    int check_count = 0;
    apfg_stream_source memSource (.clk_sys, .stream(memStream));
    apfg_stream_source gndSource (.clk_sys, .stream(gndStream));
    apfg_function_generator apfg_function_generator_inst (.clk_sys, .rst,
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .missionTime, .memStream,
        .gndStream, .segRequest, .gimbalCtl, .gimbalData, .gimbalClk);
    // =====
    // Clock and shared tasks
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // One cycle of a bounded wait; a spent bound ends the run
    task automatic tick(inout int n);
        @(posedge clk_sys);
        n++;
        if (n > 2000) begin
            bad_count++;
            $display("unexpected wait: expected answer, seen timeout");
            end_of_test();
        end
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n = 0;
        @(posedge clk_sys);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            tick(n);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
        end while (bValid !== 1'b1);
        bReady <= 1'b0;
        cmp("bresp", 32'(e), 32'(bResp));
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk_sys);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            tick(n);
            if (arValid && arReady) arValid <= 1'b0;
        end while (rValid !== 1'b1);
        rReady <= 1'b0;
        d = rData;
        r = rResp;
    endtask
    // Collects one gimbal frame, bit taken at each pulse
    task automatic getFrame(output logic [ANG_W-1:0] v);
        int n = 0;
        while (gimbalCtl !== 1'b1) tick(n);
        for (int k = 0; k < ANG_W; k++) begin
            do tick(n); while (gimbalClk !== 1'b1);
            v[k] = gimbalData;
        end
    endtask
    // =====
    // Scenarios
    task automatic testRegs();
        logic [31:0] d;
        logic [1:0] r;
        axiRead(OFF_CTRL, d, r);
        cmp("ctrl reset", 32'(CTRL_RST), d);
        axiWrite(OFF_TAG0, 32'hFFFF_C005, RESP_OKAY);
        axiRead(OFF_TAG0, d, r);
        cmp("tag", 32'h0000_0005, d);
        axiRead(8'hFC, d, r);
        cmp("unmapped", 32'(RESP_SLVERR), 32'(r));
        axiWrite(8'hFC, 32'h0000_0001, RESP_SLVERR);
    endtask
    task automatic testLoad(input logic gnd, input logic [LOAD_W-1:0] w);
        logic [ANG_W-1:0] v;
        logic [31:0] d;
        logic [1:0] r;
        fork
            if (gnd) gndSource.send(w); else memSource.send(w);
            getFrame(v);
        join
        cmp("start angle", 32'(w[13:0]), 32'(v));
        axiRead(OFF_STAT, d, r);
        cmp("loaded", 32'(w), 32'(d[19:0]));
    endtask
    task automatic stepCheck(input logic [MT_W-1:0] mt, input logic [ANG_W-1:0] e);
        logic [ANG_W-1:0] v;
        missionTime <= mt;
        getFrame(v);
        cmp("stepped angle", 32'(e), 32'(v));
    endtask
    task automatic noFrame(input logic [MT_W-1:0] mt);
        int seen = 0;
        missionTime <= mt;
        repeat (200) begin
            @(posedge clk_sys);
            if (gimbalCtl !== 1'b0 || gimbalClk !== 1'b0) seen++;
        end
        cmp("frame cycles", 32'h0, 32'(seen));
    endtask
    task automatic testTag();
        int n = 0;
        axiWrite(OFF_CTRL, 32'h0000_0021, RESP_OKAY);
        missionTime <= 26'h000_5000;
        do tick(n); while (segRequest !== 1'b1);
        @(posedge clk_sys);
        cmp("request pulse", 32'h0, {31'h0, segRequest});
    endtask
    // =====
    // Main sequence
    initial begin
        rst = 1'b1;
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        awAddr = 8'h00;
        arAddr = 8'h00;
        wData = 32'h0000_0000;
        missionTime = 26'h000_0000;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        testRegs();
        testLoad(1'b0, {6'h05, 14'h1234});
        axiWrite(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
        stepCheck(26'h000_1000, 14'h1239);
        noFrame(26'h000_2000);
        stepCheck(26'h000_3000, 14'h123E);
        testTag();
        testLoad(1'b1, {6'h3E, 14'h0001});
        axiWrite(OFF_CTRL, 32'h0000_001B, RESP_OKAY);
        noFrame(26'h000_6000);
        noFrame(26'h000_7000);
        stepCheck(26'h200_7000, 14'h3FFF);
        axiWrite(OFF_CTRL, 32'h0000_021B, RESP_OKAY);
        noFrame(26'h000_7000);
        noFrame(26'h200_7000);
        end_of_test();
    end
endmodule
bind apfg_function_generator apfg_monitor apfg_monitor_inst (.clk_sys, .rst,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .gimbalCtl, .gimbalData, .gimbalClk);
